//--- hw/oad_pkg.sv
// constants and types shared by the operand address decoder
package oad_pkg;
   localparam int unsigned OAD_XLEN   = 32;
   localparam int unsigned OAD_ILEN   = 16;
   localparam int unsigned OAD_RNUM_W = 4;

   typedef logic [OAD_XLEN-1:0]   oad_word_t;
   typedef logic [OAD_ILEN-1:0]   oad_instr_t;
   typedef logic [OAD_RNUM_W-1:0] oad_rnum_t;

   // instruction field positions
   localparam int unsigned OAD_HI_MSB  = 11;
   localparam int unsigned OAD_HI_LSB  = 8;
   localparam int unsigned OAD_LO_MSB  = 7;
   localparam int unsigned OAD_LO_LSB  = 4;
   localparam int unsigned OAD_D4_MSB  = 3;
   localparam int unsigned OAD_D8_MSB  = 7;
   localparam int unsigned OAD_D12_MSB = 11;
   localparam int unsigned OAD_F_LSB   = 0;

   localparam oad_rnum_t OAD_R0_NUM = 4'h0;

   // scaling and step sizes
   localparam logic [1:0] OAD_SH_BYTE = 2'h0;
   localparam logic [1:0] OAD_SH_WORD = 2'h1;
   localparam logic [1:0] OAD_SH_LONG = 2'h2;
   localparam logic [1:0] OAD_SH_PC   = 2'h1;
   localparam logic [1:0] OAD_SH_TRAP = 2'h2;
   localparam oad_word_t  OAD_STEP_BYTE = 32'h0000_0001;
   localparam oad_word_t  OAD_STEP_WORD = 32'h0000_0002;
   localparam oad_word_t  OAD_STEP_LONG = 32'h0000_0004;
   localparam oad_word_t  OAD_ZERO      = 32'h0000_0000;

   typedef enum logic [1:0] {
      OAD_SZ_BYTE = 2'b00,
      OAD_SZ_WORD = 2'b01,
      OAD_SZ_LONG = 2'b10
   } oad_size_t;

   typedef enum logic [3:0] {
      OAD_FMT_ZERO = 4'b0000,
      OAD_FMT_N    = 4'b0001,
      OAD_FMT_M    = 4'b0010,
      OAD_FMT_NM   = 4'b0011,
      OAD_FMT_MD   = 4'b0100,
      OAD_FMT_ND4  = 4'b0101,
      OAD_FMT_NMD  = 4'b0110,
      OAD_FMT_D    = 4'b0111,
      OAD_FMT_D12  = 4'b1000,
      OAD_FMT_ND8  = 4'b1001,
      OAD_FMT_I    = 4'b1010,
      OAD_FMT_NI   = 4'b1011
   } oad_fmt_t;

   typedef enum logic [3:0] {
      OAD_AM_NONE      = 4'b0000,
      OAD_AM_DIRECT    = 4'b0001,
      OAD_AM_INDIRECT  = 4'b0010,
      OAD_AM_POST_INC  = 4'b0011,
      OAD_AM_PRE_DEC   = 4'b0100,
      OAD_AM_DISP4     = 4'b0101,
      OAD_AM_INDEXED   = 4'b0110,
      OAD_AM_GBR_DISP  = 4'b0111,
      OAD_AM_PC_DISP8  = 4'b1000,
      OAD_AM_PC_DISP12 = 4'b1001,
      OAD_AM_PC_REG    = 4'b1010,
      OAD_AM_MAC       = 4'b1011
   } oad_mode_t;

   typedef enum logic [1:0] {
      OAD_IMM_NONE = 2'b00,
      OAD_IMM_ZEXT = 2'b01,
      OAD_IMM_SEXT = 2'b10,
      OAD_IMM_TRAP = 2'b11
   } oad_imm_t;
endpackage

//--- hw/oad_field_extract.sv
// register number and displacement field extraction per format
`timescale 1ns/10ps
module oad_field_extract
   import oad_pkg::*;
(
   input  oad_instr_t   instr_word,
   input  oad_fmt_t     fmt,
   output oad_rnum_t    dst_num,
   output oad_rnum_t    src_num,
   output logic [3:0]   disp4,
   output logic [7:0]   disp8,
   output logic [11:0]  disp12
);
   oad_rnum_t hi_field;
   oad_rnum_t lo_field;

   // the field value is the register number, 0000 is register zero
   assign hi_field = instr_word[OAD_HI_MSB:OAD_HI_LSB];
   assign lo_field = instr_word[OAD_LO_MSB:OAD_LO_LSB];
   assign disp4    = instr_word[OAD_D4_MSB:OAD_F_LSB];
   assign disp8    = instr_word[OAD_D8_MSB:OAD_F_LSB];
   assign disp12   = instr_word[OAD_D12_MSB:OAD_F_LSB];

   always_comb
   begin
      dst_num = OAD_R0_NUM;
      src_num = OAD_R0_NUM;
      case (fmt)
         OAD_FMT_N:
         begin
            dst_num = hi_field;
         end
         OAD_FMT_M:
         begin
            src_num = hi_field;
         end
         OAD_FMT_NM, OAD_FMT_NMD:
         begin
            dst_num = hi_field;
            src_num = lo_field;
         end
         OAD_FMT_MD:
         begin
            src_num = lo_field;
            dst_num = OAD_R0_NUM;
         end
         OAD_FMT_ND4:
         begin
            dst_num = lo_field;
            src_num = OAD_R0_NUM;
         end
         OAD_FMT_D, OAD_FMT_I:
         begin
            dst_num = OAD_R0_NUM;
            src_num = OAD_R0_NUM;
         end
         OAD_FMT_ND8, OAD_FMT_NI:
         begin
            dst_num = hi_field;
         end
         default:
         begin
            dst_num = OAD_R0_NUM;
            src_num = OAD_R0_NUM;
         end
      endcase
   end
endmodule

//--- hw/oad_operand_address_decode.sv
// operand field decode, effective address and immediate generation
`timescale 1ns/10ps
module oad_operand_address_decode
   import oad_pkg::*;
(
   input  logic       clk_sys,
   input  logic       rst,
   input  logic       instr_valid,
   input  oad_instr_t instr_word,
   input  oad_fmt_t   fmt,
   input  oad_mode_t  mode,
   input  oad_size_t  op_size,
   input  oad_imm_t   imm_kind,
   input  logic       base_is_src,
   input  logic       pc_rel_is_load,
   input  oad_word_t  src_value,
   input  oad_word_t  dst_value,
   input  oad_word_t  r0_value,
   input  oad_word_t  gbr_value,
   input  oad_word_t  pc_value,
   output oad_rnum_t  dst_num,
   output oad_rnum_t  src_num,
   output logic       operand_is_register,
   output oad_rnum_t  operand_reg_num,
   output logic       mem_access,
   output oad_word_t  eff_addr,
   output oad_word_t  mac_addr_b,
   output logic       target_valid,
   output logic       mac_to_accum,
   output oad_word_t  imm_value,
   output logic       wb_a_en_ff,
   output oad_rnum_t  wb_a_num_ff,
   output oad_word_t  wb_a_value_ff,
   output logic       wb_b_en_ff,
   output oad_rnum_t  wb_b_num_ff,
   output oad_word_t  wb_b_value_ff
);
   logic [3:0]  disp4;
   logic [7:0]  disp8;
   logic [11:0] disp12;
   logic [1:0]  size_sh;
   oad_word_t   step;
   oad_word_t   base_value;
   oad_rnum_t   base_num;
   oad_word_t   d4_scaled;
   oad_word_t   d8_scaled;
   oad_word_t   d8_pc;
   oad_word_t   d12_pc;
   logic        nxt_wb_a_en;
   oad_rnum_t   nxt_wb_a_num;
   oad_word_t   nxt_wb_a_value;
   logic        nxt_wb_b_en;
   oad_rnum_t   nxt_wb_b_num;
   oad_word_t   nxt_wb_b_value;

   oad_field_extract u_fields
   (
      .instr_word (instr_word),
      .fmt        (fmt),
      .dst_num    (dst_num),
      .src_num    (src_num),
      .disp4      (disp4),
      .disp8      (disp8),
      .disp12     (disp12)
   );

   always_comb
   begin
      size_sh = OAD_SH_BYTE;
      step    = OAD_STEP_BYTE;
      case (op_size)
         OAD_SZ_WORD:
         begin
            size_sh = OAD_SH_WORD;
            step    = OAD_STEP_WORD;
         end
         OAD_SZ_LONG:
         begin
            size_sh = OAD_SH_LONG;
            step    = OAD_STEP_LONG;
         end
         default:
         begin
            size_sh = OAD_SH_BYTE;
            step    = OAD_STEP_BYTE;
         end
      endcase
   end

   assign base_value = base_is_src ? src_value : dst_value;
   assign base_num   = base_is_src ? src_num : dst_num;

   assign d4_scaled = oad_word_t'(disp4) << size_sh;
   assign d8_scaled = oad_word_t'(disp8) << size_sh;
   assign d8_pc     = oad_word_t'(signed'(disp8)) << OAD_SH_PC;
   assign d12_pc    = oad_word_t'(signed'(disp12)) << OAD_SH_PC;

   // purely combinational so the memory stage sees the address this cycle
   always_comb
   begin
      operand_is_register = 1'b0;
      operand_reg_num     = base_num;
      mem_access          = 1'b0;
      eff_addr            = OAD_ZERO;
      mac_addr_b          = OAD_ZERO;
      target_valid        = 1'b0;
      mac_to_accum        = 1'b0;
      case (mode)
         OAD_AM_DIRECT:
         begin
            operand_is_register = instr_valid;
         end
         OAD_AM_INDIRECT:
         begin
            mem_access = instr_valid;
            eff_addr   = base_value;
         end
         OAD_AM_POST_INC:
         begin
            mem_access = instr_valid;
            eff_addr   = base_value;
         end
         OAD_AM_PRE_DEC:
         begin
            mem_access = instr_valid;
            eff_addr   = base_value - step;
         end
         OAD_AM_DISP4:
         begin
            mem_access = instr_valid;
            eff_addr   = base_value + d4_scaled;
         end
         OAD_AM_INDEXED:
         begin
            mem_access = instr_valid;
            eff_addr   = base_value + r0_value;
         end
         OAD_AM_GBR_DISP:
         begin
            mem_access = instr_valid;
            eff_addr   = gbr_value + d8_scaled;
         end
         OAD_AM_PC_DISP8:
         begin
            mem_access   = instr_valid & pc_rel_is_load;
            target_valid = instr_valid & ~pc_rel_is_load;
            eff_addr     = pc_value + d8_pc;
         end
         OAD_AM_PC_DISP12:
         begin
            target_valid = instr_valid;
            eff_addr     = pc_value + d12_pc;
         end
         OAD_AM_PC_REG:
         begin
            target_valid = instr_valid;
            eff_addr     = pc_value + src_value;
         end
         OAD_AM_MAC:
         begin
            mem_access   = instr_valid;
            eff_addr     = src_value;
            mac_addr_b   = dst_value;
            mac_to_accum = instr_valid;
         end
         default:
         begin
            mem_access = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      case (imm_kind)
         OAD_IMM_ZEXT: imm_value = oad_word_t'(disp8);
         OAD_IMM_SEXT: imm_value = oad_word_t'(signed'(disp8));
         OAD_IMM_TRAP: imm_value = oad_word_t'(disp8) << OAD_SH_TRAP;
         default:      imm_value = OAD_ZERO;
      endcase
   end

   // pointer updates land one cycle later, after the access has used them
   always_comb
   begin
      nxt_wb_a_en    = 1'b0;
      nxt_wb_a_num   = base_num;
      nxt_wb_a_value = base_value;
      nxt_wb_b_en    = 1'b0;
      nxt_wb_b_num   = dst_num;
      nxt_wb_b_value = dst_value;
      if (instr_valid && mode == OAD_AM_POST_INC)
      begin
         nxt_wb_a_en    = 1'b1;
         nxt_wb_a_value = base_value + step;
      end
      else if (instr_valid && mode == OAD_AM_PRE_DEC)
      begin
         nxt_wb_a_en    = 1'b1;
         nxt_wb_a_value = base_value - step;
      end
      else if (instr_valid && mode == OAD_AM_MAC)
      begin
         nxt_wb_a_en    = 1'b1;
         nxt_wb_a_num   = src_num;
         nxt_wb_a_value = src_value + step;
         nxt_wb_b_en    = 1'b1;
         nxt_wb_b_value = dst_value + step;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wb_a_en_ff    <= 1'b0;
         wb_a_num_ff   <= OAD_R0_NUM;
         wb_a_value_ff <= OAD_ZERO;
      end
      else
      begin
         wb_a_en_ff    <= nxt_wb_a_en;
         wb_a_num_ff   <= nxt_wb_a_num;
         wb_a_value_ff <= nxt_wb_a_value;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wb_b_en_ff    <= 1'b0;
         wb_b_num_ff   <= OAD_R0_NUM;
         wb_b_value_ff <= OAD_ZERO;
      end
      else
      begin
         wb_b_en_ff    <= nxt_wb_b_en;
         wb_b_num_ff   <= nxt_wb_b_num;
         wb_b_value_ff <= nxt_wb_b_value;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_issue(oad_mode_t m);
      instr_valid && mode == m;
   endsequence

   property p_direct;
      s_issue(OAD_AM_DIRECT) |-> operand_is_register && !mem_access
         && operand_reg_num == base_num ##1 !wb_a_en_ff;
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct mode accessed memory or wrote back");

   property p_indirect;
      s_issue(OAD_AM_INDIRECT) |-> eff_addr == base_value && mem_access
         ##1 !wb_a_en_ff && !wb_b_en_ff;
   endproperty
   a_indirect: assert property (p_indirect)
      else $error("indirect mode address wrong or register altered");

   property p_post_inc;
      s_issue(OAD_AM_POST_INC) |-> eff_addr == base_value ##1 wb_a_en_ff
         && wb_a_num_ff == $past(base_num)
         && wb_a_value_ff == $past(base_value) + $past(step);
   endproperty
   a_post_inc: assert property (p_post_inc)
      else $error("post-increment address or update wrong");

   property p_pre_dec;
      s_issue(OAD_AM_PRE_DEC) |-> eff_addr == base_value - step
         ##1 wb_a_en_ff && wb_a_value_ff == $past(eff_addr);
   endproperty
   a_pre_dec: assert property (p_pre_dec)
      else $error("pre-decrement address or write-back wrong");

   property p_disp4_long;
      s_issue(OAD_AM_DISP4) ##0 op_size == OAD_SZ_LONG |->
         eff_addr == base_value + {26'h0, instr_word[3:0], 2'b00};
   endproperty
   a_disp4_long: assert property (p_disp4_long)
      else $error("longword displacement not scaled by four");

   property p_indexed;
      s_issue(OAD_AM_INDEXED) |-> eff_addr == base_value + r0_value;
   endproperty
   a_indexed: assert property (p_indexed)
      else $error("indexed address is not register plus register zero");

   property p_gbr_word;
      s_issue(OAD_AM_GBR_DISP) ##0 op_size == OAD_SZ_WORD |->
         eff_addr == gbr_value + {23'h0, instr_word[7:0], 1'b0};
   endproperty
   a_gbr_word: assert property (p_gbr_word)
      else $error("global base word displacement wrong");

   property p_pc12;
      s_issue(OAD_AM_PC_DISP12) |-> target_valid && eff_addr ==
         pc_value + {{19{instr_word[11]}}, instr_word[11:0], 1'b0};
   endproperty
   a_pc12: assert property (p_pc12)
      else $error("long PC-relative target wrong");

   property p_pc_reg;
      s_issue(OAD_AM_PC_REG) |-> eff_addr == pc_value + src_value
         && !mem_access;
   endproperty
   a_pc_reg: assert property (p_pc_reg)
      else $error("far branch target wrong");

   property p_imm_sext;
      imm_kind == OAD_IMM_SEXT |->
         imm_value == {{24{instr_word[7]}}, instr_word[7:0]};
   endproperty
   a_imm_sext: assert property (p_imm_sext)
      else $error("sign-extended immediate wrong");

   property p_trap;
      imm_kind == OAD_IMM_TRAP |->
         imm_value == {22'h0, instr_word[7:0], 2'b00};
   endproperty
   a_trap: assert property (p_trap)
      else $error("trap vector offset wrong");

   property p_mac;
      s_issue(OAD_AM_MAC) |-> mac_to_accum ##1 wb_a_en_ff && wb_b_en_ff
         && wb_b_num_ff == $past(instr_word[11:8])
         && wb_b_value_ff == $past(dst_value) + $past(step);
   endproperty
   a_mac: assert property (p_mac)
      else $error("upper pointer of multiply-accumulate not incremented");
endmodule

//--- tb/oad_regfile_model.sv
// register file, global base and pc source standing in for the pipeline
`timescale 1ns/10ps
module oad_regfile_model
   import oad_pkg::*;
(
   input  logic      clk_sys,
   input  oad_rnum_t src_num,
   input  oad_rnum_t dst_num,
   input  logic      wb_a_en_ff,
   input  oad_rnum_t wb_a_num_ff,
   input  oad_word_t wb_a_value_ff,
   input  logic      wb_b_en_ff,
   input  oad_rnum_t wb_b_num_ff,
   input  oad_word_t wb_b_value_ff,
   output oad_word_t src_value,
   output oad_word_t dst_value,
   output oad_word_t r0_value,
   output oad_word_t gbr_value,
   output oad_word_t pc_value
);
   // preset by the bench between instructions, so plain always below
   oad_word_t regs_ff [16];
   oad_word_t gbr_ff;
   oad_word_t pc_ff;

   assign src_value = regs_ff[src_num];
   assign dst_value = regs_ff[dst_num];
   assign r0_value  = regs_ff[0];
   assign gbr_value = gbr_ff;
   assign pc_value  = pc_ff;

   // b lands after a, so a pointer named twice ends on the upper step
   always @(posedge clk_sys)
   begin
      if (wb_a_en_ff)
         regs_ff[wb_a_num_ff] <= wb_a_value_ff;
      if (wb_b_en_ff)
         regs_ff[wb_b_num_ff] <= wb_b_value_ff;
   end
endmodule

//--- tb/tb.sv
// self-checking bench for the operand address decoder
`timescale 1ns/10ps
module tb
   import oad_pkg::*;
;
   logic       clk_sys, rst, instr_valid, base_is_src, pc_rel_is_load;
   oad_instr_t instr_word;
   oad_fmt_t   fmt;
   oad_mode_t  mode;
   oad_size_t  op_size;
   oad_imm_t   imm_kind;
   oad_word_t  src_value, dst_value, r0_value, gbr_value, pc_value;
   oad_rnum_t  dst_num, src_num, operand_reg_num, wb_a_num_ff, wb_b_num_ff;
   logic       operand_is_register, mem_access, target_valid, mac_to_accum;
   logic       wb_a_en_ff, wb_b_en_ff;
   oad_word_t  eff_addr, mac_addr_b, imm_value, wb_a_value_ff, wb_b_value_ff;
   int         error_cnt = 0;
   int         compares = 0;
   int         cyc = 0;
   oad_size_t  szs [3] = '{OAD_SZ_BYTE, OAD_SZ_WORD, OAD_SZ_LONG};

   oad_operand_address_decode dut (
      .clk_sys, .rst, .instr_valid, .instr_word, .fmt, .mode, .op_size,
      .imm_kind, .base_is_src, .pc_rel_is_load, .src_value, .dst_value,
      .r0_value, .gbr_value, .pc_value, .dst_num, .src_num,
      .operand_is_register, .operand_reg_num, .mem_access, .eff_addr,
      .mac_addr_b, .target_valid, .mac_to_accum, .imm_value, .wb_a_en_ff,
      .wb_a_num_ff, .wb_a_value_ff, .wb_b_en_ff, .wb_b_num_ff, .wb_b_value_ff
   );
   oad_regfile_model rf (
      .clk_sys, .src_num, .dst_num, .wb_a_en_ff, .wb_a_num_ff, .wb_a_value_ff,
      .wb_b_en_ff, .wb_b_num_ff, .wb_b_value_ff, .src_value, .dst_value,
      .r0_value, .gbr_value, .pc_value
   );

   initial
   begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic end_sim();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // a hang is cut off well past the 66 or so cycles the tests need
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         error_cnt = error_cnt + 1;
         end_sim();
      end
   end

   task automatic chk_w(input string nm, input oad_word_t exp,
                        input oad_word_t got);
      compares = compares + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_b(input string nm, input logic exp, input logic got);
      compares = compares + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("ERROR %s expected %b seen %b", nm, exp, got);
      end
   endtask

   function automatic oad_word_t stp(input oad_size_t s);
      case (s)
         OAD_SZ_BYTE: return 32'h0000_0001;
         OAD_SZ_WORD: return 32'h0000_0002;
         default:     return 32'h0000_0004;
      endcase
   endfunction

   // drives one instruction just after an edge; comb outputs settle by +21
   task automatic iss(input oad_instr_t iw, input oad_fmt_t f,
                      input oad_mode_t m, input oad_size_t sz,
                      input logic bis, input oad_imm_t ik = OAD_IMM_NONE,
                      input logic pl = 1'h0, input logic v = 1'h1);
      @(posedge clk_sys);
      #1;
      instr_valid    = v;
      instr_word     = iw;
      fmt            = f;
      mode           = m;
      op_size        = sz;
      imm_kind       = ik;
      base_is_src    = bis;
      pc_rel_is_load = pl;
      #20;
   endtask

   // ends the issue, checks the write-back pulse and that it lasts one cycle
   task automatic wb(input logic ea, input oad_rnum_t na, input oad_word_t va,
                     input logic eb = 1'h0, input oad_rnum_t nb = 4'h0,
                     input oad_word_t vb = 32'h0);
      @(posedge clk_sys);
      #1;
      instr_valid = 1'h0;
      #20;
      chk_b("wb_a_en", ea, wb_a_en_ff);
      chk_b("wb_b_en", eb, wb_b_en_ff);
      if (ea)
      begin
         chk_w("wb_a_num", 32'(na), 32'(wb_a_num_ff));
         chk_w("wb_a_val", va, wb_a_value_ff);
      end
      if (eb)
      begin
         chk_w("wb_b_num", 32'(nb), 32'(wb_b_num_ff));
         chk_w("wb_b_val", vb, wb_b_value_ff);
      end
      @(posedge clk_sys);
      #21;
      chk_b("wb_a_end", 1'h0, wb_a_en_ff);
      chk_b("wb_b_end", 1'h0, wb_b_en_ff);
   endtask

   task automatic t_direct();
      oad_instr_t iw;
      for (int n = 0; n < 16; n += 5)
      begin
         iw = {4'h4, 4'(n), 8'h29};
         iss(iw, OAD_FMT_N, OAD_AM_DIRECT, OAD_SZ_LONG, 1'h0);
         chk_w("dir_num", 32'(n), 32'(dst_num));
         chk_w("dir_reg", 32'(n), 32'(operand_reg_num));
         chk_b("dir_isreg", 1'h1, operand_is_register);
         chk_b("dir_mem", 1'h0, mem_access);
      end
      wb(1'h0, 4'h0, 32'h0);
   endtask

   task automatic t_indirect();
      rf.regs_ff[3] = 32'h1000_0040;
      rf.regs_ff[7] = 32'h0000_0055;
      iss(16'h2372, OAD_FMT_NM, OAD_AM_INDIRECT, OAD_SZ_LONG, 1'h0);
      chk_w("ind_dst", 32'h3, 32'(dst_num));
      chk_w("ind_src", 32'h7, 32'(src_num));
      chk_w("ind_addr", 32'h1000_0040, eff_addr);
      chk_b("ind_mem", 1'h1, mem_access);
      wb(1'h0, 4'h0, 32'h0);
   endtask

   task automatic t_post_pre();
      foreach (szs[i])
      begin
         rf.regs_ff[5] = 32'hffff_fffe;
         iss(16'h6156, OAD_FMT_NM, OAD_AM_POST_INC, szs[i], 1'h1);
         chk_w("pi_addr", 32'hffff_fffe, eff_addr);
         wb(1'h1, 4'h5, 32'hffff_fffe + stp(szs[i]));
         rf.regs_ff[2] = 32'h0;
         iss(16'h2296, OAD_FMT_NM, OAD_AM_PRE_DEC, szs[i], 1'h0);
         chk_w("pd_addr", 32'h0 - stp(szs[i]), eff_addr);
         wb(1'h1, 4'h2, 32'h0 - stp(szs[i]));
      end
   endtask

   task automatic t_disp();
      rf.regs_ff[0] = 32'h0000_0100;
      rf.regs_ff[4] = 32'h2000_0000;
      rf.regs_ff[6] = 32'hffff_ff80;
      foreach (szs[i])
      begin
         iss(16'h514f, OAD_FMT_NMD, OAD_AM_DISP4, szs[i], 1'h1);
         chk_w("d4_dst", 32'h1, 32'(dst_num));
         chk_w("d4_src", 32'h4, 32'(src_num));
         chk_w("d4_addr", 32'h2000_0000 + 32'hf * stp(szs[i]), eff_addr);
         iss(16'h0636, OAD_FMT_NM, OAD_AM_INDEXED, szs[i], 1'h0);
         chk_w("ix_addr", 32'h0000_0080, eff_addr);
         iss(16'hc5ff, OAD_FMT_D, OAD_AM_GBR_DISP, szs[i], 1'h0);
         chk_w("gb_addr", 32'h4000_0000 + 32'hff * stp(szs[i]), eff_addr);
         chk_w("gb_dst", 32'h0, 32'(dst_num));
      end
      iss(16'h8143, OAD_FMT_ND4, OAD_AM_DISP4, OAD_SZ_BYTE, 1'h0);
      chk_w("nd4_dst", 32'h4, 32'(dst_num));
      chk_w("nd4_src", 32'h0, 32'(src_num));
      chk_w("nd4_addr", 32'h2000_0003, eff_addr);
      iss(16'h854f, OAD_FMT_MD, OAD_AM_DISP4, OAD_SZ_WORD, 1'h1);
      chk_w("md_dst", 32'h0, 32'(dst_num));
      chk_w("md_addr", 32'h2000_001e, eff_addr);
      wb(1'h0, 4'h0, 32'h0);
   endtask

   task automatic t_pc();
      rf.regs_ff[12] = 32'h0000_0234;
      iss(16'h8b80, OAD_FMT_D, OAD_AM_PC_DISP8, OAD_SZ_WORD, 1'h0);
      chk_w("p8_addr", 32'h0000_0f00, eff_addr);
      chk_b("p8_tgt", 1'h1, target_valid);
      iss(16'h9a7f, OAD_FMT_ND8, OAD_AM_PC_DISP8, OAD_SZ_WORD, 1'h0,
          OAD_IMM_NONE, 1'h1);
      chk_w("pl_dst", 32'ha, 32'(dst_num));
      chk_w("pl_addr", 32'h0000_10fe, eff_addr);
      chk_b("pl_mem", 1'h1, mem_access);
      chk_b("pl_tgt", 1'h0, target_valid);
      iss(16'ha800, OAD_FMT_D12, OAD_AM_PC_DISP12, OAD_SZ_WORD, 1'h0);
      chk_w("p12_addr", 32'h0, eff_addr);
      chk_b("p12_tgt", 1'h1, target_valid);
      iss(16'h0c23, OAD_FMT_M, OAD_AM_PC_REG, OAD_SZ_LONG, 1'h1);
      chk_w("pr_src", 32'hc, 32'(src_num));
      chk_w("pr_addr", 32'h0000_1234, eff_addr);
      wb(1'h0, 4'h0, 32'h0);
   endtask

   task automatic t_imm();
      oad_imm_t  ks [3] = '{OAD_IMM_ZEXT, OAD_IMM_SEXT, OAD_IMM_TRAP};
      oad_word_t ex [3] = '{32'h0000_0085, 32'hffff_ff85, 32'h0000_0214};
      foreach (ks[k])
      begin
         iss(16'he385, OAD_FMT_NI, OAD_AM_NONE, OAD_SZ_LONG, 1'h0, ks[k]);
         chk_w("imm_val", ex[k], imm_value);
         chk_w("imm_dst", 32'h3, 32'(dst_num));
      end
      iss(16'he385, OAD_FMT_I, OAD_AM_NONE, OAD_SZ_LONG, 1'h0, OAD_IMM_ZEXT);
      chk_w("i_dst", 32'h0, 32'(dst_num));
      chk_w("i_src", 32'h0, 32'(src_num));
      chk_w("i_val", 32'h0000_0085, imm_value);
      wb(1'h0, 4'h0, 32'h0);
   endtask

   task automatic t_mac_idle();
      rf.regs_ff[8] = 32'h0000_0100;
      rf.regs_ff[9] = 32'h0000_0200;
      iss(16'h498f, OAD_FMT_NM, OAD_AM_MAC, OAD_SZ_WORD, 1'h1);
      chk_w("mac_a", 32'h0000_0100, eff_addr);
      chk_w("mac_b", 32'h0000_0200, mac_addr_b);
      chk_b("mac_acc", 1'h1, mac_to_accum);
      wb(1'h1, 4'h8, 32'h0000_0102, 1'h1, 4'h9, 32'h0000_0202);
      iss(16'h6156, OAD_FMT_NM, OAD_AM_POST_INC, OAD_SZ_LONG, 1'h1,
          OAD_IMM_NONE, 1'h0, 1'h0);
      chk_b("idle_mem", 1'h0, mem_access);
      wb(1'h0, 4'h0, 32'h0);
   endtask

   initial
   begin
      rst            = 1'h1;
      instr_valid    = 1'h0;
      instr_word     = 16'h0;
      fmt            = OAD_FMT_ZERO;
      mode           = OAD_AM_NONE;
      op_size        = OAD_SZ_BYTE;
      imm_kind       = OAD_IMM_NONE;
      base_is_src    = 1'h0;
      pc_rel_is_load = 1'h0;
      for (int i = 0; i < 16; i++)
         rf.regs_ff[i] = 32'h0;
      rf.gbr_ff = 32'h4000_0000;
      rf.pc_ff  = 32'h0000_1000;
      repeat (8) @(posedge clk_sys);
      #1;
      rst = 1'h0;
      chk_b("rst_wb_a", 1'h0, wb_a_en_ff);
      chk_b("rst_wb_b", 1'h0, wb_b_en_ff);
      t_direct();
      t_indirect();
      t_post_pre();
      t_disp();
      t_pc();
      t_imm();
      t_mac_idle();
      end_sim();
   end
endmodule
